// file: stn_notch_bank.sv
// What this block does
// (RULE1) four notch groups: frequency, width, depth each
// (RULE2) groups 3,4 manual; groups 1,2 also adaptive
// (RULE3) mode bit0/bit1 make group 1/2 adaptive
// (RULE4) adaptive groups follow detected vibration while running
// (RULE5) bit4/bit5 save tuned group then go manual
// (RULE6) freeze written zero holds last adaptive values
// (RULE7) 5000 hz frequency makes group pass through
// (RULE8) mode zero: all manual, no updates
// (RULE9) low-pass cutoff set by time constant
// (RULE10) midlow suppressor frequency 50..2000, default 100
// (RULE11) midlow damping 0..300, default 150
// (RULE12) midlow compensation 0..1000, default 100
// (RULE13) deviation above threshold flags low-frequency resonance
// (RULE14) resonance period default 0 ms, mode 0
// (RULE15) speed feedforward gain 0 %, filter 1.00 ms
// (RULE16) speed feedback filter time 1.00 ms
// (RULE17) observer gain 400 hz, coefficient 0 %
// (RULE18) depth 0 passes, 60 mostly blocks, deeper beyond
// (RULE19) low-pass then four notches, one sample each
`timescale 1ns/1ps
`default_nettype none

module stn_notch_bank #(
  parameter int SW              = 16,      // torque sample width
  parameter int SAMPLE_RATE_HZ  = 16000    // control cycle rate
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic signed [SW-1:0]  tq_in,
  input  wire logic                  tq_in_valid,
  output logic                       tq_in_ready,
  output logic signed [SW-1:0]       tq_out,
  output logic                       tq_out_valid,
  input  wire logic                  servo_running,
  input  wire logic                  est_valid,
  input  wire logic                  est_group,
  input  wire logic [15:0]           est_freq,
  input  wire logic [15:0]           est_width,
  input  wire logic [15:0]           est_depth,
  input  wire logic                  est_settled,
  input  wire logic signed [15:0]    pos_dev,
  output logic                       lowfreq_res,
  output logic [15:0]                midlow_vib_freq,
  output logic [15:0]                midlow_vib_damping,
  output logic [15:0]                midlow_vib_comp,
  output logic [15:0]                lowfreq_res_mode,
  output logic [15:0]                lowfreq_res_period,
  output logic [15:0]                speed_ff_filter_time,
  output logic [15:0]                speed_ff_gain,
  output logic [15:0]                speed_fb_lpf_time,
  output logic [15:0]                disturbance_obs_gain,
  output logic [15:0]                disturbance_comp_coef
);
  import stn_pkg::*;

  localparam int IW = SW + 8;  // internal width, headroom for resonance
  // sample period in 0.01 ms units, at least one
  localparam int TS_CENTI_RAW = int'(1.0e3 / (SAMPLE_RATE_HZ * TS_UNIT_MS));
  localparam int TS_CENTI = (TS_CENTI_RAW < 1) ? 1 : TS_CENTI_RAW;
  // 2*pi/fs in q22, so that f*scale>>8 is q14
  localparam int FSCALE = int'(TWO_PI_Q22 / SAMPLE_RATE_HZ);

  ////////////////////////////////////////////////////////////////////////
  // apb register file

  logic [15:0]             regs [0:NUM_REGS-1];       // settings
  logic [15:0]             next_regs [0:NUM_REGS-1];
  logic [4:0]              widx;                       // word index
  logic                    in_map;                     // address decodes
  logic                    wr_strobe;                  // apb write taken
  logic                    lowfreq_next;
  stn_state_type           state;
  stn_state_type           next_state;

  assign widx        = paddr[6:2];
  assign in_map      = (paddr[11:7] == 5'h00);
  assign wr_strobe   = psel && penable && pwrite && in_map;
  assign pready      = 1'b1;  // zero wait states
  assign pslverr     = psel && penable && !in_map;

  // read mux; status word is assembled live
  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && in_map && !pwrite) begin
      if (widx == 5'(IDX_STATUS)) begin
        prdata = {29'h0000_0000, state != ST_IDLE, lowfreq_res,
                  servo_running};
      end else begin
        prdata = {16'h0000, regs[widx]};
      end
    end
  end

  // next register values: software writes, then adaptive updates
  always_comb begin
    logic [15:0] wv;
    logic [15:0] mode_now;
    int          gbase;
    wv = pwdata[15:0];
    mode_now = 16'h0000;
    gbase = 0;
    for (int i = 0; i < NUM_REGS; i++) begin
      next_regs[i] = regs[i];
    end
    if (wr_strobe && widx != 5'(IDX_STATUS)) begin
      // midlow settings saturate into their legal ranges
      if (widx == 5'(IDX_MID_FREQ)) begin
        if (wv < MID_FREQ_MIN) begin
          wv = MID_FREQ_MIN;  // RULE10
        end else if (wv > MID_FREQ_MAX) begin
          wv = MID_FREQ_MAX;  // RULE10
        end
      end else if (widx == 5'(IDX_MID_DAMP) && wv > MID_DAMP_MAX) begin
        wv = MID_DAMP_MAX;  // RULE11
      end else if (widx == 5'(IDX_MID_COMP) && wv > MID_COMP_MAX) begin
        wv = MID_COMP_MAX;  // RULE12
      end
      next_regs[widx] = wv;
    end
    // estimator result for group 1 or 2 only; groups 3,4 stay manual
    mode_now = regs[IDX_MODE];
    gbase = IDX_NOTCH_BASE + (est_group ? NOTCH_STRIDE : 0);
    if (est_valid && servo_running                                  // RULE4
        && mode_now[est_group ? MODE_ADAPT2 : MODE_ADAPT1]          // RULE3 RULE8
        && regs[IDX_FREEZE] != 16'h0000                             // RULE6
        && !wr_strobe) begin
      // a software write in the same cycle wins over the estimator
      next_regs[gbase + OFS_FREQ]  = est_freq;                      // RULE2
      next_regs[gbase + OFS_WIDTH] = est_width;
      next_regs[gbase + OFS_DEPTH] = est_depth;
      if (est_settled && mode_now[est_group ? MODE_SAVE2 : MODE_SAVE1]) begin
        // keep tuned values and drop back to manual
        next_regs[IDX_MODE][est_group ? MODE_ADAPT2 : MODE_ADAPT1] = 1'b0;  // RULE5
      end
    end
  end

  // register storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= REG_RESET[i];  // RULE14 RULE15 RULE16 RULE17
      end
    end else begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= next_regs[i];
      end
    end
  end

  // settings handed to the speed loop and suppressors
  assign midlow_vib_freq       = regs[IDX_MID_FREQ];    // RULE10
  assign midlow_vib_damping    = regs[IDX_MID_DAMP];    // RULE11
  assign midlow_vib_comp       = regs[IDX_MID_COMP];    // RULE12
  assign lowfreq_res_mode      = regs[IDX_LFR_MODE];    // RULE14
  assign lowfreq_res_period    = regs[IDX_LFR_PERIOD];  // RULE14
  assign speed_ff_filter_time  = regs[IDX_FF_TIME];     // RULE15
  assign speed_ff_gain         = regs[IDX_FF_GAIN];     // RULE15
  assign speed_fb_lpf_time     = regs[IDX_FB_TIME];     // RULE16
  assign disturbance_obs_gain  = regs[IDX_OBS_GAIN];    // RULE17
  assign disturbance_comp_coef = regs[IDX_OBS_COEF];    // RULE17

  ////////////////////////////////////////////////////////////////////////
  // low-frequency resonance flag

  // magnitude of deviation against the pulse threshold
  always_comb begin
    logic [15:0] mag;
    mag = pos_dev[15] ? 16'(-pos_dev) : 16'(pos_dev);
    lowfreq_next = (mag > regs[IDX_LFR_THR]);  // RULE13
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lowfreq_res <= 1'b0;
    end else begin
      lowfreq_res <= lowfreq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // filter sequencer: one shared multiplier, one step per cycle

  logic signed [IW-1:0]    x;             // sample under work
  logic signed [IW-1:0]    lpf_y;         // low-pass state
  logic signed [IW-1:0]    lp_s [0:3];    // notch low-pass states
  logic signed [IW-1:0]    bp_s [0:3];    // notch band-pass states
  logic signed [IW-1:0]    hp;            // high-pass of current group
  logic [1:0]              grp;           // current notch group
  logic signed [IW-1:0]    next_x;
  logic signed [IW-1:0]    next_lpf_y;
  logic signed [IW-1:0]    next_lp_s [0:3];
  logic signed [IW-1:0]    next_bp_s [0:3];
  logic signed [IW-1:0]    next_hp;
  logic [1:0]              next_grp;
  logic signed [SW-1:0]    next_tq_out;
  logic                    next_tq_out_valid;
  logic signed [IW-1:0]    mul_a;         // multiplier operand
  logic [15:0]             mul_c;         // q14 coefficient
  logic signed [IW-1:0]    mul_r;         // scaled product
  logic [15:0]             f_coef;        // tuning coefficient
  logic [15:0]             q_coef;        // damping from width
  logic [15:0]             g_coef;        // cut gain from depth
  logic                    bypass;        // group disabled
  logic [3:0]              lpf_shift;     // low-pass step size

  assign tq_in_ready = (state == ST_IDLE);  // samples while busy are refused

  // coefficients of the current group
  always_comb begin
    logic [31:0] fprod;
    logic [15:0] fr;
    logic [15:0] dp;
    int          b;
    b      = IDX_NOTCH_BASE + int'(grp) * NOTCH_STRIDE;
    fr     = regs[b + OFS_FREQ];
    dp     = regs[b + OFS_DEPTH];
    bypass = (fr == NOTCH_OFF_FREQ);  // RULE7
    fprod  = 32'(fr) * 32'(FSCALE);
    // small-angle tuning, clamped at one to keep the loop stable
    f_coef = (fprod[31:8] > 24'(COEF_ONE)) ? COEF_ONE : fprod[23:8];
    // width level is the bandwidth ratio, level 2 gives unity damping
    q_coef = 16'(regs[b + OFS_WIDTH] << (COEF_FRAC - 1));
    // depth 0 leaves the band alone, 64 and over cut it fully
    g_coef = (dp >= 16'(DEPTH_FULL)) ? COEF_ONE
             : 16'(dp << (COEF_FRAC - 6));  // RULE18
  end

  // low-pass step: smallest k with ts*2^k >= tc+ts
  always_comb begin
    logic [31:0] span;
    span = 32'(regs[IDX_TCF_TIME]) + 32'(TS_CENTI);
    lpf_shift = 4'hf;
    for (int k = 15; k >= 0; k--) begin
      if ((32'(TS_CENTI) << k) >= span) begin
        lpf_shift = 4'(k);  // RULE9
      end
    end
  end

  // shared multiplier
  always_comb begin
    logic signed [IW+16:0] prod;
    prod  = mul_a * $signed({1'b0, mul_c});
    mul_r = IW'(prod >>> COEF_FRAC);
  end

  // next sequencer values
  always_comb begin
    logic signed [IW-1:0] bp_new;
    bp_new            = bp_s[grp];
    next_state        = state;
    next_x            = x;
    next_lpf_y        = lpf_y;
    next_hp           = hp;
    next_grp          = grp;
    next_tq_out       = tq_out;
    next_tq_out_valid = 1'b0;
    mul_a             = '0;
    mul_c             = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      next_lp_s[i] = lp_s[i];
      next_bp_s[i] = bp_s[i];
    end
    unique case (state)
      ST_IDLE: begin
        if (tq_in_valid) begin
          next_x     = IW'(tq_in);
          next_state = ST_LPF;
        end
      end
      ST_LPF: begin
        // first order low-pass ahead of the notches
        next_lpf_y = lpf_y + ((x - lpf_y) >>> lpf_shift);  // RULE9 RULE19
        next_x     = next_lpf_y;
        next_grp   = 2'd0;
        next_state = ST_NLP;
      end
      ST_NLP: begin
        if (bypass) begin
          // disabled group: sample passes untouched
          if (grp == 2'd3) begin
            next_tq_out       = (x > IW'(2**(SW-1)-1)) ? SW'(2**(SW-1)-1)
                                : (x < -IW'(2**(SW-1))) ? SW'(-(2**(SW-1)))
                                : SW'(x);
            next_tq_out_valid = 1'b1;
            next_state        = ST_IDLE;
          end else begin
            next_grp = grp + 2'd1;  // RULE7 RULE19
          end
        end else begin
          mul_a           = bp_s[grp];
          mul_c           = f_coef;
          next_lp_s[grp]  = lp_s[grp] + mul_r;  // RULE1
          next_state      = ST_NHP;
        end
      end
      ST_NHP: begin
        mul_a      = bp_s[grp];
        mul_c      = q_coef;
        next_hp    = x - lp_s[grp] - mul_r;  // RULE1
        next_state = ST_NBP;
      end
      ST_NBP: begin
        mul_a          = hp;
        mul_c          = f_coef;
        next_bp_s[grp] = bp_s[grp] + mul_r;
        next_state     = ST_NOUT;
      end
      ST_NOUT: begin
        // remove the band, scaled by the depth level
        mul_a  = bp_new;
        mul_c  = g_coef;
        next_x = x - mul_r;  // RULE18
        if (grp == 2'd3) begin
          next_tq_out       = (next_x > IW'(2**(SW-1)-1)) ? SW'(2**(SW-1)-1)
                              : (next_x < -IW'(2**(SW-1))) ? SW'(-(2**(SW-1)))
                              : SW'(next_x);
          next_tq_out_valid = 1'b1;
          next_state        = ST_IDLE;
        end else begin
          next_grp   = grp + 2'd1;  // RULE19
          next_state = ST_NLP;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= ST_IDLE;
      x            <= '0;
      lpf_y        <= '0;
      hp           <= '0;
      grp          <= 2'd0;
      tq_out       <= '0;
      tq_out_valid <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        lp_s[i] <= '0;
        bp_s[i] <= '0;
      end
    end else begin
      state        <= next_state;
      x            <= next_x;
      lpf_y        <= next_lpf_y;
      hp           <= next_hp;
      grp          <= next_grp;
      tq_out       <= next_tq_out;
      tq_out_valid <= next_tq_out_valid;
      for (int i = 0; i < 4; i++) begin
        lp_s[i] <= next_lp_s[i];
        bp_s[i] <= next_bp_s[i];
      end
    end
  end

endmodule // stn_notch_bank

`default_nettype wire

// file: stn_notch_bank_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// watches the sample stream and exported settings from the ports alone
module stn_notch_bank_assertions #(
  parameter int SW = 16  // sample width
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic                 pslverr,
  input wire logic                 tq_in_valid,
  input wire logic                 tq_in_ready,
  input wire logic signed [SW-1:0] tq_out,
  input wire logic                 tq_out_valid,
  input wire logic signed [15:0]   pos_dev,
  input wire logic                 lowfreq_res,
  input wire logic [15:0]          midlow_vib_freq,
  input wire logic [15:0]          midlow_vib_damping,
  input wire logic [15:0]          midlow_vib_comp,
  input wire logic [15:0]          lowfreq_res_mode,
  input wire logic [15:0]          lowfreq_res_period,
  input wire logic [15:0]          speed_ff_filter_time,
  input wire logic [15:0]          speed_ff_gain,
  input wire logic [15:0]          speed_fb_lpf_time,
  input wire logic [15:0]          disturbance_obs_gain,
  input wire logic [15:0]          disturbance_comp_coef
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////
  logic [15:0] dev_mag;  // magnitude of deviation, threshold left at 5
  assign dev_mag = pos_dev[15] ? 16'(-pos_dev) : 16'(pos_dev);
  // stream steps: take, five quiet cycles, then a result
  sequence s_take; tq_in_valid && tq_in_ready; endsequence
  sequence s_quiet; !tq_out_valid [*5]; endsequence
  property p_latency; s_take |=> s_quiet ##[1:13] tq_out_valid; endproperty
  a_latency: assert property (p_latency) else $error("result outside 6..18 cycles");
  property p_busy; s_take |=> !tq_in_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready stayed high after take");
  property p_pulse; tq_out_valid |=> !tq_out_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("result valid longer than one cycle");
  property p_hold; !tq_out_valid |-> $stable(tq_out); endproperty
  a_hold: assert property (p_hold) else $error("output moved without valid");
  property p_lowfreq; lowfreq_res == ($past(dev_mag) > 16'h0005); endproperty
  a_lowfreq: assert property (p_lowfreq) else $error("resonance flag wrong");
  property p_freq; midlow_vib_freq >= 16'h0032 && midlow_vib_freq <= 16'h07d0; endproperty
  a_freq: assert property (p_freq) else $error("suppressor frequency out of range");
  property p_clamp; midlow_vib_damping <= 16'h012c && midlow_vib_comp <= 16'h03e8; endproperty
  a_clamp: assert property (p_clamp) else $error("damping or compensation out of range");
  property p_fwr;
    psel && penable && pwrite && paddr == 12'h050 && pwdata[15:0] >= 16'h0032 && pwdata[15:0] <= 16'h07d0
      |=> midlow_vib_freq == $past(pwdata[15:0]);
  endproperty
  a_fwr: assert property (p_fwr) else $error("frequency write not applied at once");
  property p_dflt;
    $rose(presetn) |-> midlow_vib_freq == 16'h0064 && midlow_vib_damping == 16'h0096 &&
      midlow_vib_comp == 16'h0064 && lowfreq_res_period == 16'h0000 && speed_ff_gain == 16'h0000 &&
      speed_ff_filter_time == 16'h0064 && speed_fb_lpf_time == 16'h0064 && lowfreq_res_mode == 16'h0000 &&
      disturbance_obs_gain == 16'h0190 && disturbance_comp_coef == 16'h0000;
  endproperty
  a_dflt: assert property (p_dflt) else $error("setting not at default after reset");
  property p_err; psel && penable && paddr[11:7] != 5'h00 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("bad address not flagged");
endmodule // stn_notch_bank_assertions
`default_nettype wire

// file: stn_notch_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module stn_notch_bank_tb;
  typedef struct packed {logic [4:0] idx; logic [15:0] wd; logic [15:0] ex;} stn_row_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tq_in_valid, tq_in_ready;
  logic tq_out_valid, servo_running, est_valid, est_group, est_settled, lowfreq_res, erv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic signed [15:0] tq_in, tq_out, pos_dev;
  logic [15:0] est_freq, est_width, est_depth;
  int fail_count, total_checks, cyc;
  // settings after reset
  stn_row_type dflt [0:15] = '{'{0,0,0}, '{4,0,5000}, '{8,0,5000}, '{12,0,5000}, '{16,0,5000},
    '{20,0,100}, '{21,0,150}, '{22,0,100}, '{23,0,5}, '{24,0,0}, '{25,0,0}, '{26,0,100},
    '{27,0,0}, '{28,0,100}, '{29,0,400}, '{30,0,0}};
  // writes and the value read back, clamps included
  stn_row_type rows [0:10] = '{'{20,10,50}, '{20,3000,2000}, '{20,1500,1500}, '{21,400,300},
    '{21,0,0}, '{22,2000,1000}, '{22,1000,1000}, '{24,3,3}, '{25,7,7}, '{29,1200,1200}, '{31,7,0}};
  logic [16:0] lf [0:3] = '{{16'sd6, 1'b1}, {16'sd5, 1'b0}, {-16'sd6, 1'b1}, {-16'sd5, 1'b0}};
  stn_notch_bank stn_notch_bank_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .tq_in, .tq_in_valid, .tq_in_ready, .tq_out, .tq_out_valid,
    .servo_running, .est_valid, .est_group, .est_freq, .est_width, .est_depth, .est_settled,
    .pos_dev, .lowfreq_res, .midlow_vib_freq(), .midlow_vib_damping(), .midlow_vib_comp(),
    .lowfreq_res_mode(), .lowfreq_res_period(), .speed_ff_filter_time(), .speed_ff_gain(),
    .speed_fb_lpf_time(), .disturbance_obs_gain(), .disturbance_comp_coef());
  stn_torque_partner stn_torque_partner_i (.pclk, .tq_out_valid, .tq_out, .tq_in, .tq_in_valid,
    .est_valid, .est_group, .est_freq, .est_width, .est_depth, .est_settled);
  //////////////////////////////
  always #20 pclk = ~pclk;
  // hang guard, far above the few hundred cycles used
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] wd);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, 16'h0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    erv = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    apb(1'b1, {5'h00, i, 2'b00}, d);
  endtask
  task automatic rd_chk(input logic [4:0] i, input logic [15:0] e);
    apb(1'b0, {5'h00, i, 2'b00}, 16'h0000);
    chk(rdv, {16'h0000, e});
  endtask
  task automatic est_chk(input logic g, input logic [15:0] f, input logic s, input logic [4:0] i,
                         input logic [15:0] e);
    stn_torque_partner_i.estimate(g, f, s);
    rd_chk(i, e);
  endtask
  task automatic run(input logic v);
    @(posedge pclk);
    servo_running <= v;
  endtask
  //////////////////////////////
  initial begin
    {pclk, presetn, psel, penable, pwrite, servo_running} = '0;
    {paddr, pwdata, pos_dev} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (dflt[i]) rd_chk(dflt[i].idx, dflt[i].ex);
    $display("defaults done");
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd);
      rd_chk(rows[i].idx, rows[i].ex);
    end
    $display("settings table done");
    // zero filter time makes the low-pass a copy, bypassed notches pass too
    wr(5'd2, 16'h0000);
    stn_torque_partner_i.send(16'sh1234);
    chk(32'(stn_torque_partner_i.lat), 32'h6);
    chk({16'h0000, stn_torque_partner_i.got}, 32'h1234);
    stn_torque_partner_i.send(-16'sh0ff3);
    chk({16'h0000, stn_torque_partner_i.got}, 32'hf00d);
    // each group switched on adds its three extra steps
    for (int g = 0; g < 4; g++) begin
      wr(5'(4 + 4 * g), 16'd1000);
      stn_torque_partner_i.send(16'sh0100);
      chk(32'(stn_torque_partner_i.lat), 32'(6 + 3 * (g + 1)));
    end
    $display("stream done");
    run(1'b1);
    wr(5'd0, 16'h0001);
    est_chk(1'b0, 16'd800, 1'b0, 5'd4, 16'd800);
    rd_chk(5'd6, 16'h0028);
    est_chk(1'b1, 16'd900, 1'b0, 5'd8, 16'd1000);
    run(1'b0);
    est_chk(1'b0, 16'd700, 1'b0, 5'd4, 16'd800);
    run(1'b1);
    wr(5'd1, 16'h0000);
    est_chk(1'b0, 16'd600, 1'b0, 5'd4, 16'd800);
    wr(5'd1, 16'h0001);
    wr(5'd0, 16'h0000);
    est_chk(1'b0, 16'd600, 1'b0, 5'd4, 16'd800);
    wr(5'd0, 16'h0022);
    est_chk(1'b1, 16'd1200, 1'b1, 5'd8, 16'd1200);
    rd_chk(5'd0, 16'h0020);
    $display("adaptive done");
    foreach (lf[i]) begin
      @(posedge pclk);
      pos_dev <= lf[i][16:1];
      repeat (2) @(posedge pclk);
      #1;
      chk({31'h0, lowfreq_res}, {31'h0, lf[i][0]});
    end
    $display("resonance flag done");
    apb(1'b1, 12'h850, 16'h0077);
    chk({31'h0, erv}, 32'h1);
    rd_chk(5'd20, 16'd1500);
    $display("bad address done");
    end_sim();
  end
endmodule // stn_notch_bank_tb
bind stn_notch_bank stn_notch_bank_assertions #(.SW(SW)) stn_notch_bank_assertions_i (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .tq_in_valid, .tq_in_ready, .tq_out,
  .tq_out_valid, .pos_dev, .lowfreq_res, .midlow_vib_freq, .midlow_vib_damping, .midlow_vib_comp,
  .lowfreq_res_mode, .lowfreq_res_period, .speed_ff_filter_time, .speed_ff_gain, .speed_fb_lpf_time,
  .disturbance_obs_gain, .disturbance_comp_coef);
`default_nettype wire

// file: stn_pkg.sv
// shared constants for the torque command notch filter bank
package stn_pkg;

  // register indexes; byte address is four times the index
  localparam int IDX_MODE        = 0;   // adaptive_notch_mode_select
  localparam int IDX_FREEZE      = 1;   // adaptive_update_freeze
  localparam int IDX_TCF_TIME    = 2;   // torque_cmd_filter_time, 0.01 ms
  localparam int IDX_NOTCH_BASE  = 4;   // group n at base + 4*(n-1)
  localparam int NOTCH_STRIDE    = 4;
  localparam int OFS_FREQ        = 0;   // hz
  localparam int OFS_WIDTH       = 1;   // width level
  localparam int OFS_DEPTH       = 2;   // depth level
  localparam int IDX_MID_FREQ    = 20;  // midlow_vib_freq
  localparam int IDX_MID_DAMP    = 21;  // midlow_vib_damping
  localparam int IDX_MID_COMP    = 22;  // midlow_vib_comp
  localparam int IDX_LFR_THR     = 23;  // lowfreq_res_dev_threshold
  localparam int IDX_LFR_MODE    = 24;  // lowfreq_res_mode
  localparam int IDX_LFR_PERIOD  = 25;  // lowfreq_res_period, ms
  localparam int IDX_FF_TIME     = 26;  // speed_ff_filter_time, 0.01 ms
  localparam int IDX_FF_GAIN     = 27;  // speed_ff_gain, %
  localparam int IDX_FB_TIME     = 28;  // speed_fb_lpf_time, 0.01 ms
  localparam int IDX_OBS_GAIN    = 29;  // disturbance_obs_gain, hz
  localparam int IDX_OBS_COEF    = 30;  // disturbance_comp_coef, %
  localparam int IDX_STATUS      = 31;  // read only
  localparam int NUM_REGS        = 32;

  // mode select bit positions
  localparam int MODE_ADAPT1     = 0;
  localparam int MODE_ADAPT2     = 1;
  localparam int MODE_SAVE1      = 4;
  localparam int MODE_SAVE2      = 5;

  // notch bypass value and setting limits
  localparam logic [15:0] NOTCH_OFF_FREQ = 16'h1388;  // 5000 hz
  localparam logic [15:0] MID_FREQ_MIN   = 16'h0032;  // 50
  localparam logic [15:0] MID_FREQ_MAX   = 16'h07d0;  // 2000
  localparam logic [15:0] MID_DAMP_MAX   = 16'h012c;  // 300
  localparam logic [15:0] MID_COMP_MAX   = 16'h03e8;  // 1000

  // values after reset
  localparam logic [15:0] REG_RESET [0:NUM_REGS-1] = '{
    16'h0000, 16'h0001, 16'h0064, 16'h0000,   // mode, freeze, 1.00 ms
    16'h1388, 16'h0002, 16'h0000, 16'h0000,   // group 1
    16'h1388, 16'h0002, 16'h0000, 16'h0000,   // group 2
    16'h1388, 16'h0002, 16'h0000, 16'h0000,   // group 3
    16'h1388, 16'h0002, 16'h0000, 16'h0000,   // group 4
    16'h0064, 16'h0096, 16'h0064, 16'h0005,   // 100 hz, 150 %, 100 %, 5 pulses
    16'h0000, 16'h0000, 16'h0064, 16'h0000,   // mode 0, 0 ms, 1.00 ms, 0 %
    16'h0064, 16'h0190, 16'h0000, 16'h0000};  // 1.00 ms, 400 hz, 0 %, status

  // fixed point: coefficients are q14
  localparam int COEF_FRAC       = 14;
  localparam logic [15:0] COEF_ONE = 16'h4000;
  localparam int DEPTH_FULL      = 64;        // depth level giving full cut
  localparam real TS_UNIT_MS     = 0.01;      // time setting unit
  localparam real TWO_PI_Q22     = 26353589.0; // 2*pi*2^22

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LPF  = 3'b001,
    ST_NLP  = 3'b010,
    ST_NHP  = 3'b011,
    ST_NBP  = 3'b100,
    ST_NOUT = 3'b101
  } stn_state_type;

endpackage

// file: stn_torque_partner.sv
`timescale 1ns/1ps
`default_nettype none
// speed loop side: offers torque samples, plays the vibration estimator
module stn_torque_partner (
  input wire logic                pclk,
  input wire logic                tq_out_valid,
  input wire logic signed [15:0]  tq_out,
  output logic signed [15:0]      tq_in,
  output logic                    tq_in_valid,
  output logic                    est_valid,
  output logic                    est_group,
  output logic [15:0]             est_freq,
  output logic [15:0]             est_width,
  output logic [15:0]             est_depth,
  output logic                    est_settled
);
  int                 lat;  // cycles from take to result
  logic signed [15:0] got;  // last result seen
  initial begin
    {tq_in, tq_in_valid, est_valid, est_group, est_settled, est_freq, est_width, est_depth} = '0;
  end
  //////////////////////////////
  // one sample; data inverted after the take so a stale value cannot pass
  task automatic send(input logic signed [15:0] v);
    @(posedge pclk);
    tq_in <= v;
    tq_in_valid <= 1'b1;
    @(posedge pclk);
    tq_in <= ~v;
    tq_in_valid <= 1'b0;
    lat = 1;  // counts up to the edge that samples the result pulse high
    do begin
      @(posedge pclk);
      #1;
      lat++;
    end while (!tq_out_valid && lat < 40);
    got = tq_out;
  endtask
  // one estimator pulse, fields scrambled afterwards
  task automatic estimate(input logic g, input logic [15:0] f, input logic s);
    @(posedge pclk);
    {est_valid, est_group, est_settled} <= {1'b1, g, s};
    {est_freq, est_width, est_depth} <= {f, 16'h0003, 16'h0028};
    @(posedge pclk);
    {est_valid, est_group, est_settled} <= {1'b0, ~g, ~s};
    {est_freq, est_width, est_depth} <= {~f, 16'hfffc, 16'hffd7};
  endtask
endmodule // stn_torque_partner
`default_nettype wire
